// [src/modulo_timer_defs.vh]
// Purpose: Register map, field positions and reset values of the modulo timer
// Assumes: Included by bare name from the timer design files
// Notes: Offsets are byte addresses on the AXI4-Lite register bus
`ifndef MODULO_TIMER_DEFS_VH
`define MODULO_TIMER_DEFS_VH
`define STATUS_CONTROL_OFS 4'h0
`define CLOCK_CONFIG_OFS 4'h4
`define COUNT_OFS 4'h8
`define MODULO_LIMIT_OFS 4'hC
`define OVF_FLAG_BIT 7
`define OVF_IRQ_EN_BIT 6
`define CNT_RESET_BIT 5
`define HALT_BIT 4
`define SRC_SEL_HI 5
`define SRC_SEL_LO 4
`define PRESCALE_HI 3
`define PRESCALE_LO 0
`define SRC_BUS 2'b00
`define SRC_FIXED 2'b01
`define SRC_EXT_FALL 2'b10
`define SRC_EXT_RISE 2'b11
`define PRESCALE_MAX 4'h8
`define COUNT_RESET 8'h00
`define MODULO_RESET 8'h00
`define CLOCK_CONFIG_RESET 6'h00
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// [src/clock_source_prescaler.v]
// Purpose: Select the count source edge and divide it by a power of two
// Assumes: All inputs are already synchronous to sys_clk
// Notes: countTick is a one-cycle enable; the counter never runs on a derived clock
`timescale 1ns/1ps
`include "modulo_timer_defs.vh"
module clock_source_prescaler #(
  parameter DIV_WIDTH = 8
) (
  input wire sys_clk,
  input wire reset_n,
  input wire run,
  input wire clear,
  input wire [1:0] clockSourceSelect,
  input wire [3:0] prescaleSelect,
  input wire fixedFreqClock,
  input wire extClockSync,
  output wire countTick
);
  reg fixedPrev_reg;
  reg extPrev_reg;
  reg [DIV_WIDTH-1:0] div_reg;
  reg [DIV_WIDTH-1:0] div_next;
  reg srcEdge;
  reg [DIV_WIDTH-1:0] divMask;
  // Edge history of the slower sources
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fixedPrev_reg <= 1'b0;
      extPrev_reg <= 1'b0;
    end else begin
      fixedPrev_reg <= fixedFreqClock;
      extPrev_reg <= extClockSync;
    end
  end
  // Four selectable source edges
  always @* begin
    case (clockSourceSelect)
      `SRC_BUS: srcEdge = 1'b1;
      `SRC_FIXED: srcEdge = fixedFreqClock & ~fixedPrev_reg;
      `SRC_EXT_FALL: srcEdge = ~extClockSync & extPrev_reg;
      default: srcEdge = extClockSync & ~extPrev_reg;
    endcase
  end
  // Codes above eight clamp to the longest ratio
  always @* begin
    if (prescaleSelect >= `PRESCALE_MAX) begin
      divMask = {DIV_WIDTH{1'b1}};
    end else begin
      divMask = ~({DIV_WIDTH{1'b1}} << prescaleSelect);
    end
  end
  // Tick when the low field bits of the divider are all ones on a source edge
  assign countTick = run & srcEdge & ((div_reg & divMask) == divMask);
  always @* begin
    div_next = div_reg;
    if (clear) begin
      div_next = {DIV_WIDTH{1'b0}};
    end else if (run & srcEdge) begin
      div_next = div_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= {DIV_WIDTH{1'b0}};
    end else begin
      div_reg <= div_next;
    end
  end
endmodule

// [src/modulo_timer.v]
// Purpose: 8-bit modulo timer with selectable source, prescaler and AXI4-Lite registers
// Assumes: Power-mode and debug inputs are synchronous to sys_clk; the pin input is not
// Notes: Wait mode needs no special handling; the timer simply keeps its bus clock
// Overview of operation
// - 8-bit up-counter, free running or limited by a programmable modulo value
// - Software-enabled overflow interrupt gives periodic requests
// - One control bit resets the counter, another halts it
// - Prescaler source is bus clock, fixed clock, pin rise or pin fall
// - Prescaler divides by a power of two from 1 to 256
// - Pin is the source when the upper select bit is set
// - Pin input may also feed the timer/PWM unit at the same time
// - Counting and overflow interrupt continue during wait mode
// - Timer stops in every stop mode and never wakes the core
// - Deep stop wake-up, or light stop left by reset, restores reset state
// - Light stop left by interrupt keeps state and resumes the count
// - Counting is suspended during active background-debug mode
// - After debug, count resumes unless reset bit or modulo write occurred
// - Pin input is synchronised by the bus clock before use
// - Four 8-bit registers: status/control, clock config, count, modulo
// - Overflow flag sets when the counter wraps from modulo to zero
// - Flag clears by read-then-write-zero, reset bit write, or modulo write
// - Reset sets the halt bit; clearing it resumes from the held value
// - Prescale codes 0 to 8 give two to the code; above give 256
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "modulo_timer_defs.vh"
module modulo_timer #(
  parameter ADDR_WIDTH = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire extTimerClockIn,
  input wire fixedFreqClock,
  input wire stopActive,
  input wire deepStopWake,
  input wire lightStopResetExit,
  input wire debugActive,
  output wire extClockToTimerPwm,
  output wire irqRequest
);
  reg extSync1_reg;
  reg extSync2_reg;
  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg [7:0] moduloLimit_reg;
  reg ovfFlag_reg;
  reg ovfFlag_next;
  reg ovfIrqEnable_reg;
  reg counterHalt_reg;
  reg [5:0] clockConfig_reg;
  reg flagSeen_reg;
  reg awHeld_reg;
  reg wHeld_reg;
  reg [ADDR_WIDTH-1:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg [7:0] moduloLimit_next;
  reg [5:0] clockConfig_next;
  reg ovfIrqEnable_next;
  reg counterHalt_next;
  reg flagSeen_next;
  reg awHeld_next;
  reg wHeld_next;
  reg [ADDR_WIDTH-1:0] awAddr_next;
  reg [31:0] wData_next;
  reg [3:0] wStrb_next;
  reg bValid_next;
  reg [1:0] bResp_next;
  reg rValid_next;
  reg [31:0] rData_next;
  reg [1:0] rResp_next;
  wire awTake;
  wire wTake;
  wire doWrite;
  wire [ADDR_WIDTH-1:0] wrAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  wire lane0;
  wire writeStatus;
  wire writeClock;
  wire writeModulo;
  wire counterResetPulse;
  wire moduleReset;
  wire run;
  wire countTick;
  wire wrapNow;
  wire readTake;
  wire readStatus;
  wire wrMapped;
  reg [7:0] readByte;
  reg readMapped;

  // Two-flop synchroniser for the timer clock pin
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync1_reg <= 1'b0;
      extSync2_reg <= 1'b0;
    end else begin
      extSync1_reg <= extTimerClockIn;
      extSync2_reg <= extSync1_reg;
    end
  end

  // Raw pin is shared with the timer/PWM unit; it does its own sync
  assign extClockToTimerPwm = extTimerClockIn;

  // Write address and data may arrive in either order; each is held until both are here
  assign awTake = s_axi_awvalid & s_axi_awready;
  assign wTake = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  assign wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  assign wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  assign wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  assign doWrite = (awHeld_reg | awTake) & (wHeld_reg | wTake);
  assign lane0 = wrStrb[0];
  assign wrMapped = (wrAddr == `STATUS_CONTROL_OFS) | (wrAddr == `CLOCK_CONFIG_OFS) |
                    (wrAddr == `COUNT_OFS) | (wrAddr == `MODULO_LIMIT_OFS);
  // Registers are one byte; only lane 0 carries them
  assign writeStatus = doWrite & lane0 & (wrAddr == `STATUS_CONTROL_OFS);
  assign writeClock = doWrite & lane0 & (wrAddr == `CLOCK_CONFIG_OFS);
  assign writeModulo = doWrite & lane0 & (wrAddr == `MODULO_LIMIT_OFS);

  // Write channel next state: each half is parked until its partner arrives, then both retire together
  always @* begin
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = s_axi_bvalid;
    bResp_next = s_axi_bresp;
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      // Count register is read-only, so writes to it are harmless but accepted
      bResp_next = wrMapped ? `AXI_OKAY : `AXI_SLVERR;
    end else begin
      if (awTake) begin
        awHeld_next = 1'b1;
        awAddr_next = s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_next = 1'b1;
        wData_next = s_axi_wdata;
        wStrb_next = s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        bValid_next = 1'b0;
      end
    end
  end

  // Write channel registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= {ADDR_WIDTH{1'b0}};
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      s_axi_bvalid <= bValid_next;
      s_axi_bresp <= bResp_next;
    end
  end

  // Counter reset strobe: reset bit written one, or any modulo write
  assign counterResetPulse = (writeStatus & wrData[`CNT_RESET_BIT]) | writeModulo;
  // Wake from deep stop, or light stop left by reset, gives reset state
  assign moduleReset = deepStopWake | lightStopResetExit;
  // Stop and debug freeze counting; light stop exit by interrupt keeps all state
  assign run = ~counterHalt_reg & ~stopActive & ~debugActive;

  // Divider keeps its phase across a counter reset write; only reset_n, a stop wake or a reset exit from light stop clears it
  clock_source_prescaler #(
    .DIV_WIDTH(8)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(run),
    .clear(moduleReset),
    .clockSourceSelect(clockConfig_reg[`SRC_SEL_HI:`SRC_SEL_LO]),
    .prescaleSelect(clockConfig_reg[`PRESCALE_HI:`PRESCALE_LO]),
    .fixedFreqClock(fixedFreqClock),
    .extClockSync(extSync2_reg),
    .countTick(countTick)
  );

  // Modulo zero means the full 8-bit range is used
  assign wrapNow = countTick & (count_reg == moduloLimit_reg) & (moduloLimit_reg != 8'h00) |
                   countTick & (moduloLimit_reg == 8'h00) & (count_reg == 8'hFF);

  // Counter next value; a reset strobe beats a tick in the same cycle
  always @* begin
    count_next = count_reg;
    if (counterResetPulse) begin
      count_next = `COUNT_RESET;
    end else if (wrapNow) begin
      count_next = 8'h00;
    end else if (countTick) begin
      count_next = count_reg + 8'h01;
    end
  end

  // Flag: a wrap in the clearing cycle wins over the clear
  always @* begin
    ovfFlag_next = ovfFlag_reg;
    if (counterResetPulse) begin
      ovfFlag_next = 1'b0;
    end else if (writeStatus & flagSeen_reg & ~wrData[`OVF_FLAG_BIT]) begin
      ovfFlag_next = 1'b0;
    end
    if (wrapNow) begin
      ovfFlag_next = 1'b1;
    end
  end

  // Software-visible control fields
  always @* begin
    moduloLimit_next = moduloLimit_reg;
    clockConfig_next = clockConfig_reg;
    ovfIrqEnable_next = ovfIrqEnable_reg;
    counterHalt_next = counterHalt_reg;
    if (writeModulo) begin
      moduloLimit_next = wrData[7:0];
    end
    if (writeClock) begin
      clockConfig_next = wrData[5:0];
    end
    if (writeStatus) begin
      ovfIrqEnable_next = wrData[`OVF_IRQ_EN_BIT];
      counterHalt_next = wrData[`HALT_BIT];
    end
  end

  // Arm the clear sequence when software has read the flag set; a status write disarms it unless such a read comes in the same cycle
  always @* begin
    flagSeen_next = flagSeen_reg;
    if (readStatus & ovfFlag_reg) begin
      flagSeen_next = 1'b1;
    end else if (writeStatus | ~ovfFlag_reg) begin
      flagSeen_next = 1'b0;
    end
  end

  // State registers; a stop wake or a reset exit from light stop restores reset values
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `COUNT_RESET;
      moduloLimit_reg <= `MODULO_RESET;
      ovfFlag_reg <= 1'b0;
      ovfIrqEnable_reg <= 1'b0;
      counterHalt_reg <= 1'b1;
      clockConfig_reg <= `CLOCK_CONFIG_RESET;
      flagSeen_reg <= 1'b0;
    end else if (moduleReset) begin
      count_reg <= `COUNT_RESET;
      moduloLimit_reg <= `MODULO_RESET;
      ovfFlag_reg <= 1'b0;
      ovfIrqEnable_reg <= 1'b0;
      counterHalt_reg <= 1'b1;
      clockConfig_reg <= `CLOCK_CONFIG_RESET;
      flagSeen_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovfFlag_reg <= ovfFlag_next;
      moduloLimit_reg <= moduloLimit_next;
      ovfIrqEnable_reg <= ovfIrqEnable_next;
      counterHalt_reg <= counterHalt_next;
      clockConfig_reg <= clockConfig_next;
      flagSeen_reg <= flagSeen_next;
    end
  end

  // Level request; wait mode keeps it live so it can wake the core
  assign irqRequest = ovfFlag_reg & ovfIrqEnable_reg;

  // Read channel: one outstanding read, answered the cycle after address
  assign s_axi_arready = ~s_axi_rvalid;
  assign readTake = s_axi_arvalid & s_axi_arready;
  assign readStatus = readTake & (s_axi_araddr == `STATUS_CONTROL_OFS);

  // Read mux; reads have no side effect beyond arming the flag clear
  always @* begin
    readByte = 8'h00;
    readMapped = 1'b1;
    case (s_axi_araddr)
      `STATUS_CONTROL_OFS: readByte = {ovfFlag_reg, ovfIrqEnable_reg, 1'b0, counterHalt_reg, 4'h0};
      `CLOCK_CONFIG_OFS: readByte = {2'b00, clockConfig_reg};
      `COUNT_OFS: readByte = count_reg;
      `MODULO_LIMIT_OFS: readByte = moduloLimit_reg;
      default: readMapped = 1'b0;
    endcase
  end

  // Read channel next state; data stands unchanged until rready is seen
  always @* begin
    rValid_next = s_axi_rvalid;
    rData_next = s_axi_rdata;
    rResp_next = s_axi_rresp;
    if (readTake) begin
      rValid_next = 1'b1;
      rData_next = {24'h00_0000, readByte};
      rResp_next = readMapped ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  // Read channel registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_rvalid <= rValid_next;
      s_axi_rdata <= rData_next;
      s_axi_rresp <= rResp_next;
    end
  end
endmodule

// [sim/modulo_timer_checker.sv]
// Purpose: Port-level checks of the modulo timer
// Assumes: Bound to the top module; one clock domain
// Notes: Counter contents are judged by the bench model
`timescale 1ns/1ps
module modulo_timer_checker #(
  parameter ADDR_WIDTH = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire extTimerClockIn,
  input wire stopActive,
  input wire extClockToTimerPwm,
  input wire irqRequest
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Shared pin, bus answer timing, read data width and unmapped read error
  property p_pin_share; extClockToTimerPwm == extTimerClockIn; endproperty
  a_pin_share: assert property (p_pin_share) else $error("pin share differs");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_ar_ready; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("arready wrong");
  property p_byte_wide; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_err; s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2; endproperty
  a_rd_err: assert property (p_rd_err) else $error("unaligned read accepted");
  // Frozen timer cannot raise a request without a register write
  property p_frozen; $past(stopActive, 2) && $past(stopActive) && stopActive && !s_axi_bvalid |-> !$rose(irqRequest);
  endproperty
  a_frozen: assert property (p_frozen) else $error("request rose in stop");
endmodule
bind modulo_timer modulo_timer_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_modulo_timer_checker (.sys_clk(sys_clk),
  .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .extTimerClockIn(extTimerClockIn), .stopActive(stopActive), .extClockToTimerPwm(extClockToTimerPwm),
  .irqRequest(irqRequest));

// [sim/modulo_timer_tb_top.sv]
// Purpose: Self-checking bench for the modulo timer
// Assumes: Counter reaches the count after edges divided by the prescale
// Notes: Source pulses last eight cycles, far below a quarter of bus rate
`timescale 1ns/1ps
module modulo_timer_tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic extTimerClockIn = 1'b0, fixedFreqClock = 1'b0, stopActive = 1'b0, debugActive = 1'b0;
  logic deepStopWake = 1'b0, lightStopResetExit = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, extClockToTimerPwm, irqRequest;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fails = 0, testsRun = 0, cycles = 0, seed = 32'h1c98;
  integer k, src, ps, md, n, ticks;
  logic [31:0] rd;
  logic [1:0] rs;
  logic slowR = 1'b0;

  modulo_timer i_modulo_timer (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .extTimerClockIn(extTimerClockIn), .fixedFreqClock(fixedFreqClock), .stopActive(stopActive),
    .deepStopWake(deepStopWake), .lightStopResetExit(lightStopResetExit), .debugActive(debugActive),
    .extClockToTimerPwm(extClockToTimerPwm), .irqRequest(irqRequest)
  );

  // Clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      printVerdict();
    end
  end

  task printVerdict;
    if (fails == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun = testsRun + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Each channel is released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // A slow read raises rready only once rvalid is seen, so the answer must stand a cycle
  task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= ~slowR;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wok(input logic [3:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    check(nm, d, e);
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  // Whole pulses, rise then fall, on the fixed clock or the pin
  task automatic pulses(input integer sel, input integer cnt);
    repeat (cnt) begin
      if (sel == 1) fixedFreqClock <= 1'b1; else extTimerClockIn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (sel == 1) fixedFreqClock <= 1'b0; else extTimerClockIn <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask

  task automatic resetState;
    rchk(4'h0, 32'h0000_0010, "status_rst");
    rchk(4'h4, 32'h0, "clkcfg_rst");
    rchk(4'h8, 32'h0, "count_rst");
    rchk(4'hC, 32'h0, "modulo_rst");
    check("irq_rst", {31'h0, irqRequest}, 32'h0);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    resetState();
    rdr(4'h2, rd, rs);
    check("rd_unmapped", {30'h0, rs}, 32'h2);
    wr(4'h3, 8'hFF, rs);
    check("wr_unmapped", {30'h0, rs}, 32'h2);
    // Bus clock free run wraps past FF
    wok(4'h0, 8'h40);
    repeat (300) @(posedge sys_clk);
    check("irq_free", {31'h0, irqRequest}, 32'h1);
    wok(4'h0, 8'h50);
    rdr(4'h8, rd, rs);
    wok(4'h8, 8'h55);
    rchk(4'h8, rd, "count_held");
    rchk(4'h0, 32'h0000_00D0, "status_flag");
    wok(4'h0, 8'h50);
    rchk(4'h0, 32'h0000_0050, "status_clr");
    // Counted sources, random prescale and modulo
    for (k = 0; k < 12; k = k + 1) begin
      src = 1 + k % 3;
      slowR = k[0];
      ps = (k == 11) ? 9 : ($random(seed) & 3);
      md = 1 + ($random(seed) & 7);
      n = 4 + ($random(seed) & 31);
      if (k % 2) deepStopWake <= 1'b1; else lightStopResetExit <= 1'b1;
      @(posedge sys_clk);
      deepStopWake <= 1'b0;
      lightStopResetExit <= 1'b0;
      resetState();
      wok(4'hC, md[7:0]);
      wok(4'h4, {2'h0, src[1:0], ps[3:0]});
      wok(4'h0, 8'h40);
      pulses(src == 1, n);
      repeat (8) @(posedge sys_clk);
      ticks = n >> ((ps > 8) ? 8 : ps);
      rchk(4'h8, ticks % (md + 1), "count");
      rchk(4'h0, (ticks > md) ? 32'h0000_00C0 : 32'h0000_0040, "status");
      check("irq", {31'h0, irqRequest}, {31'h0, ticks > md});
      wok(4'h0, 8'h40);
      rchk(4'h0, 32'h0000_0040, "status_ack");
      // Stop or debug freezes the count
      if (k % 2) stopActive <= 1'b1; else debugActive <= 1'b1;
      pulses(src == 1, 6);
      stopActive <= 1'b0;
      debugActive <= 1'b0;
      rchk(4'h8, ticks % (md + 1), "count_frozen");
      if (k & 2) wok(4'h0, 8'h60); else wok(4'hC, md[7:0]);
      rchk(4'h8, 32'h0, "count_clr");
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    resetState();
    printVerdict();
  end
endmodule
